// ### rtl/cli_pkg.sv
// Constants, types and opcode layout for the character display instruction unit.
// Assumes a 20 MHz core clock; host timing is referred to the 540 kHz oscillator.
// Operation
// - Text write with shift enabled shifts display: left if direction 1, else right
// - No display shift on text reads, glyph accesses or with shift disabled
// - Display on shows everything; off blanks it but keeps text memory
// - Cursor on shows cursor; off hides it, direction setting kept
// - Blink swaps cursor cell with all-ones pixels every 185 ms
// - Shift command: cursor moves with counter step, or whole display shifts
// - Display shift leaves address counter alone; all lines shift together
// - Two-line mode: cursor past column 40 of line one goes to line two
// - Bus width bit 1 selects 8-bit host bus, 0 selects two-nibble 4-bit bus
// - Line count and font height choose 1/8, 1/11 or 1/16 duty format
// - Instruction 01xxxxxx loads six-bit glyph address; data then targets glyph memory
// - Instruction 1xxxxxxx loads seven-bit text address within line ranges
// - Status read returns busy on bit 7 and counter below, parallel only
// - Data write stores byte in chosen memory, then counter steps by one
// - Data read returns holding register, then counter steps; address set prefetches it
// - Cursor shift reloads data holding register from text memory like address set
// - After a write, a read returns only the earlier prefetched byte
// - 4-bit mode: high nibble then low on lines 7:4; busy after second
// - Strap pins select parallel, two-wire or four-line serial interface
// - Direction 1 moves cursor right and increments; 0 moves left, decrements
package cli_pkg;

   // Core clock and derived timing
   localparam int CLK_MHZ      = 20;
   localparam int EXEC_NS      = 18500;
   localparam int EXEC_CYCLES  = (EXEC_NS * CLK_MHZ + 999) / 1000;
   localparam int BLINK_MS     = 185;
   localparam int BLINK_CYCLES = BLINK_MS * CLK_MHZ * 1000;

   // Text memory address map
   localparam logic [6:0] LINE1_END    = 7'h27;
   localparam logic [6:0] LINE2_BASE   = 7'h40;
   localparam logic [6:0] LINE2_END    = 7'h67;
   localparam logic [6:0] ONE_LINE_END = 7'h4F;
   localparam logic [5:0] SHIFT_LAST   = 6'h27;

   // Opcode prefixes, matched against the top bits of an instruction byte
   localparam logic [1:0] OPC_GLYPH = 2'h1;
   localparam logic [2:0] OPC_FUNC  = 3'h1;
   localparam logic [3:0] OPC_SHIFT = 4'h1;
   localparam logic [4:0] OPC_DISP  = 5'h01;
   localparam logic [5:0] OPC_ENTRY = 6'h01;

   // Field positions inside instruction bytes
   localparam int BIT_TEXT  = 7;
   localparam int BIT_WIDTH = 4;
   localparam int BIT_LINES = 3;
   localparam int BIT_FONT  = 2;
   localparam int BIT_SC    = 3;
   localparam int BIT_RL    = 2;
   localparam int BIT_DON   = 2;
   localparam int BIT_CON   = 1;
   localparam int BIT_BON   = 0;
   localparam int BIT_DIR   = 1;
   localparam int BIT_SEN   = 0;

   typedef struct packed {
      logic display_on;
      logic cursor_on;
      logic blink_on;
      logic address_direction;
      logic display_shift_enable;
      logic bus_width_select;
      logic line_count;
      logic font_height;
   } cli_cfg_type;

   localparam cli_cfg_type CFG_RESET = '{display_on: 1'b0, cursor_on: 1'b0,
      blink_on: 1'b0, address_direction: 1'b1, display_shift_enable: 1'b0,
      bus_width_select: 1'b1, line_count: 1'b0, font_height: 1'b0};

   typedef enum logic [2:0] {
      DUTY_8  = 3'b001,
      DUTY_11 = 3'b010,
      DUTY_16 = 3'b100
   } cli_duty_type;

   typedef enum logic [2:0] {
      IF_PARALLEL = 3'b001,
      IF_TWO_WIRE = 3'b010,
      IF_SERIAL4  = 3'b100
   } cli_if_type;

   typedef enum logic [1:0] {
      PH_HIGH = 2'b01,
      PH_LOW  = 2'b10
   } cli_phase_type;

endpackage

// ### rtl/cli_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes each bit is a level; nothing but the second stage reads the first.
`timescale 1ns/1ns
module cli_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // Two flops; the first one is read only by the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta <= '0;
         q    <= '0;
      end
      else
      begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

// ### rtl/cli_core.sv
// Host port, instruction decoder, address counter and display memories.
// Assumes pins arrive asynchronously and a scanner reads text memory via scan_addr.
`timescale 1ns/1ns
module cli_core #(
   parameter int BLINK_CYCLES = cli_pkg::BLINK_CYCLES
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Parallel host pins
   input  wire logic                 enable_strobe,
   input  wire logic                 register_select,
   input  wire logic                 read_write_select,
   input  wire logic [7:0]           db_in,
   output logic      [7:0]           db_out,
   output logic                      db_oe_n,
   // Interface straps
   input  wire logic                 interface_sel_hi,
   input  wire logic                 interface_sel_lo,
   // Display scan port
   input  wire logic [6:0]           scan_addr,
   output logic      [7:0]           scan_char,
   // Status and display controls
   output cli_pkg::cli_cfg_type      cfg,
   output cli_pkg::cli_duty_type     duty,
   output cli_pkg::cli_if_type       if_mode,
   output logic      [6:0]           address_counter,
   output logic                      busy_indicator,
   output logic                      text_selected,
   output logic      [5:0]           display_offset,
   output logic                      display_visible,
   output logic                      cursor_visible,
   output logic                      cursor_solid
);

   logic [12:0]           pin_s;
   logic                  e_prev;
   logic [1:0]            strap_wait;
   cli_pkg::cli_phase_type phase;
   logic [3:0]            hi_nib;
   logic [8:0]            busy_cnt;
   logic [21:0]           blink_cnt;
   logic                  blink_phase;
   logic [7:0]            data_holding_register;
   logic [7:0]            text_ram [0:127];
   logic [7:0]            glyph_ram [0:63];

   // Counter step along the text line map or the glyph space
   function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                          input logic text, input logic two);
      logic [6:0] r;
      r = up ? a + 7'h01 : a - 7'h01;
      if (!text)
         r = {1'b0, r[5:0]};
      else if (two)
      begin
         if (up && a == cli_pkg::LINE1_END)
            r = cli_pkg::LINE2_BASE;
         else if (up && a == cli_pkg::LINE2_END)
            r = 7'h00;
         else if (!up && a == cli_pkg::LINE2_BASE)
            r = cli_pkg::LINE1_END;
         else if (!up && a == 7'h00)
            r = cli_pkg::LINE2_END;
      end
      else if (up && a == cli_pkg::ONE_LINE_END)
         r = 7'h00;
      else if (!up && a == 7'h00)
         r = cli_pkg::ONE_LINE_END;
      return r;
   endfunction

   // Display origin moves over one line of 40 columns; right shift lowers it
   function automatic logic [5:0] shift_step(input logic [5:0] o, input logic right);
      logic [5:0] r;
      if (right)
         r = (o == 6'h00) ? cli_pkg::SHIFT_LAST : o - 6'h01;
      else
         r = (o == cli_pkg::SHIFT_LAST) ? 6'h00 : o + 6'h01;
      return r;
   endfunction

   // Every pin passes two flops before use
   cli_sync #(.WIDTH(13)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     ({enable_strobe, register_select, read_write_select,
               interface_sel_hi, interface_sel_lo, db_in}),
      .q     (pin_s)
   );

   // Synchronised pin names
   wire       e_s  = pin_s[12];
   wire       rs_s = pin_s[11];
   wire       rw_s = pin_s[10];
   wire [7:0] db_s = pin_s[7:0];

   // Host transfer qualification
   wire       port_on   = (if_mode == cli_pkg::IF_PARALLEL);
   wire       wide      = cfg.bus_width_select;
   wire       strobe    = e_prev & ~e_s & port_on;
   wire       byte_done = strobe & (wide | phase == cli_pkg::PH_LOW);
   wire [7:0] byte_val  = wide ? db_s : {hi_nib, db_s[7:4]};
   wire       is_ins    = byte_done & ~rs_s & ~rw_s;
   wire       is_stat   = byte_done & ~rs_s & rw_s;
   wire       is_wr     = byte_done & rs_s & ~rw_s;
   wire       is_rd     = byte_done & rs_s & rw_s;

   // Instruction decode
   wire op_text  = is_ins & byte_val[cli_pkg::BIT_TEXT];
   wire op_glyph = is_ins & (byte_val[7:6] == cli_pkg::OPC_GLYPH);
   wire op_func  = is_ins & (byte_val[7:5] == cli_pkg::OPC_FUNC);
   wire op_shift = is_ins & (byte_val[7:4] == cli_pkg::OPC_SHIFT);
   wire op_disp  = is_ins & (byte_val[7:3] == cli_pkg::OPC_DISP);
   wire op_entry = is_ins & (byte_val[7:2] == cli_pkg::OPC_ENTRY);
   wire sc_bit   = byte_val[cli_pkg::BIT_SC];
   wire rl_bit   = byte_val[cli_pkg::BIT_RL];
   wire op_curs  = op_shift & ~sc_bit;
   wire op_dshf  = op_shift & sc_bit;

   // Address counter next value
   wire       step_dir   = op_curs ? rl_bit : cfg.address_direction;
   wire       step_ac    = op_curs | is_wr | is_rd;
   wire [6:0] stepped_ac = ac_step(address_counter, step_dir, text_selected,
                                   cfg.line_count);
   wire [6:0] next_ac    = op_text  ? byte_val[6:0] :
                           op_glyph ? {1'b0, byte_val[5:0]} :
                           step_ac  ? stepped_ac : address_counter;
   wire       next_text  = op_text | (text_selected & ~op_glyph);

   // Prefetch into the data holding register; a write never reloads it
   wire load_dhr = op_text | op_glyph | (op_curs & text_selected) | is_rd;

   // Whole-display shift: display shift command, or writes only into text memory with shift enabled
   wire shift_wr    = is_wr & text_selected & cfg.display_shift_enable;
   wire shift_disp  = shift_wr | op_dshf;
   wire shift_right = op_dshf ? rl_bit : ~cfg.address_direction;

   // Read word on the bus; status carries busy and the counter
   wire [7:0] read_word = rs_s ? data_holding_register
                               : {busy_indicator, address_counter};

   // Derived display controls
   assign display_visible = cfg.display_on;
   assign cursor_visible  = cfg.display_on & cfg.cursor_on;
   assign cursor_solid    = cursor_visible & cfg.blink_on & blink_phase;
   assign busy_indicator  = (busy_cnt != 9'h000);
   assign db_oe_n         = ~(port_on & e_s & rw_s);
   assign duty = cfg.line_count  ? cli_pkg::DUTY_16 :
                 cfg.font_height ? cli_pkg::DUTY_11 : cli_pkg::DUTY_8;

   // Straps read for three edges; the sync chain shows reset zeros for the first two,
   // so only the last capture counts. Both high falls back to parallel
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         strap_wait <= 2'h0;
         if_mode    <= cli_pkg::IF_PARALLEL;
      end
      else if (strap_wait != 2'h3)
      begin
         strap_wait <= strap_wait + 2'h1;
         if_mode    <= (pin_s[9] & ~pin_s[8]) ? cli_pkg::IF_SERIAL4 :
                       (~pin_s[9] & pin_s[8]) ? cli_pkg::IF_TWO_WIRE :
                       cli_pkg::IF_PARALLEL;
      end
   end

   // Strobe edge and nibble pairing
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         e_prev <= 1'b0;
         phase  <= cli_pkg::PH_HIGH;
         hi_nib <= 4'h0;
      end
      else
      begin
         e_prev <= e_s;
         if (op_func)
            phase <= cli_pkg::PH_HIGH;
         else if (strobe && !wide)
         begin
            case (phase)
               cli_pkg::PH_HIGH:
               begin
                  phase  <= cli_pkg::PH_LOW;
                  hi_nib <= db_s[7:4];
               end
               cli_pkg::PH_LOW: phase <= cli_pkg::PH_HIGH;
               default:         phase <= cli_pkg::PH_HIGH;
            endcase
         end
      end
   end

   // Read data from a flop; in 4-bit mode the low nibble follows on lines 7:4
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         db_out <= 8'h00;
      else if (wide || phase == cli_pkg::PH_HIGH)
         db_out <= read_word;
      else
         db_out <= {read_word[3:0], 4'h0};
   end

   // Configuration held by instructions
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cfg <= cli_pkg::CFG_RESET;
      else if (op_func)
      begin
         cfg.bus_width_select <= byte_val[cli_pkg::BIT_WIDTH];
         cfg.line_count       <= byte_val[cli_pkg::BIT_LINES];
         cfg.font_height      <= byte_val[cli_pkg::BIT_FONT];
      end
      else if (op_disp)
      begin
         cfg.display_on <= byte_val[cli_pkg::BIT_DON];
         cfg.cursor_on  <= byte_val[cli_pkg::BIT_CON];
         cfg.blink_on   <= byte_val[cli_pkg::BIT_BON];
      end
      else if (op_entry)
      begin
         cfg.address_direction    <= byte_val[cli_pkg::BIT_DIR];
         cfg.display_shift_enable <= byte_val[cli_pkg::BIT_SEN];
      end
   end

   // Address counter, memory select and display origin
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         address_counter <= 7'h00;
         text_selected   <= 1'b1;
         display_offset  <= 6'h00;
      end
      else
      begin
         address_counter <= next_ac;
         text_selected   <= next_text;
         if (shift_disp)
            display_offset <= shift_step(display_offset, shift_right);
      end
   end

   // Busy time after every executed byte; status reads do not start it
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         busy_cnt <= 9'h000;
      else if (byte_done && !is_stat)
         busy_cnt <= 9'(cli_pkg::EXEC_CYCLES);
      else if (busy_indicator)
         busy_cnt <= busy_cnt - 9'h001;
   end

   // Blink timer, held at zero while blinking is off
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         blink_cnt   <= 22'h000000;
         blink_phase <= 1'b0;
      end
      else if (!cfg.blink_on)
      begin
         blink_cnt   <= 22'h000000;
         blink_phase <= 1'b0;
      end
      else if (blink_cnt == 22'(BLINK_CYCLES - 1))
      begin
         blink_cnt   <= 22'h000000;
         blink_phase <= ~blink_phase;
      end
      else
         blink_cnt <= blink_cnt + 22'h000001;
   end

   // Memories and scan read; memory arrays carry no reset
   always_ff @(posedge clk)
   begin
      if (is_wr && text_selected)
         text_ram[address_counter] <= byte_val;
      if (is_wr && !text_selected)
         glyph_ram[address_counter[5:0]] <= byte_val;
      scan_char <= text_ram[scan_addr];
   end

   // Holding register is filled from the address about to be used
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         data_holding_register <= 8'h00;
      else if (load_dhr)
         data_holding_register <= next_text ? text_ram[next_ac]
                                            : glyph_ram[next_ac[5:0]];
   end

   default clocking dc @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence text_write_shift;
      is_wr && text_selected && cfg.display_shift_enable;
   endsequence

   shift_write_a: assert property (
      text_write_shift |=>
         display_offset == shift_step($past(display_offset), ~$past(cfg.address_direction)))
      else $error("display origin did not follow text write shift");

   no_shift_a: assert property (
      (is_rd || (is_wr && (!text_selected || !cfg.display_shift_enable))) |=>
         $stable(display_offset))
      else $error("display shifted on a read or unshifted write");

   display_off_a: assert property (
      op_disp |=> display_visible == $past(byte_val[cli_pkg::BIT_DON]))
      else $error("display on control not taken");

   cursor_off_a: assert property (
      op_disp && !byte_val[cli_pkg::BIT_CON] |=>
         !cursor_visible && $stable(cfg.address_direction))
      else $error("cursor off failed or direction lost");

   blink_hold_a: assert property (
      cfg.blink_on && blink_cnt != 22'(BLINK_CYCLES - 1) && !op_disp |=> $stable(blink_phase))
      else $error("blink toggled early");

   cursor_step_a: assert property (
      op_curs |=> address_counter == $past(stepped_ac))
      else $error("cursor shift did not step counter");

   disp_shift_ac_a: assert property (
      op_dshf |=> $stable(address_counter) ##0 display_offset != $past(display_offset))
      else $error("display shift touched counter or did not shift");

   line_wrap_a: assert property (
      op_curs && rl_bit && text_selected && cfg.line_count &&
         address_counter == cli_pkg::LINE1_END |=> address_counter == cli_pkg::LINE2_BASE)
      else $error("cursor did not carry to line two");

   glyph_addr_a: assert property (
      op_glyph |=> !text_selected && address_counter == {1'b0, $past(byte_val[5:0])})
      else $error("glyph address not loaded");

   status_word_a: assert property (
      port_on && e_s && rw_s && !rs_s && wide |=>
         db_out == {$past(busy_indicator), $past(address_counter)})
      else $error("status word wrong");

   busy_after_a: assert property (
      byte_done && !is_stat |=> busy_indicator [*8])
      else $error("busy not raised after transfer");

   first_nibble_a: assert property (
      strobe && !wide && phase == cli_pkg::PH_HIGH && !busy_indicator |=> !busy_indicator)
      else $error("busy raised after first nibble");

endmodule

// ### verif/cli_host.sv
// Host processor model on the parallel port of the instruction unit.
// Assumes a free-running clk; every pin change lands 5 ns after a rising edge.
`timescale 1ns/1ns
module cli_host (
   // Clock
   input  wire logic       clk,
   // Parallel port pins
   output logic            enable_strobe,
   output logic            register_select,
   output logic            read_write_select,
   output logic [7:0]      db_in,
   input  wire logic [7:0] db_out,
   input  wire logic       db_oe_n,
   // Read results for the bench
   output logic            rd_valid,
   output logic [7:0]      rd_data
);
   logic nibble_mode = 1'b0;

   // Idle pins from time zero
   initial
   begin
      enable_strobe = 1'b0;
      register_select = 1'b0;
      read_write_select = 1'b0;
      db_in = 8'h00;
      rd_valid = 1'b0;
      rd_data = 8'h00;
   end

   // One strobe, qualifiers held well past the synchronised fall
   task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                       output logic [7:0] q);
      @(posedge clk) #5;
      register_select = rs;
      read_write_select = rw;
      db_in = d;
      enable_strobe = 1'b1;
      repeat (4) @(posedge clk);
      #5 q = (db_oe_n === !rw) ? db_out : 8'hXX; // Undriven read data never matches
      enable_strobe = 1'b0;
      repeat (4) @(posedge clk);
      #5 db_in = ~d; // Released lines show the inverse, not a stale value
   endtask

   // Whole byte; on the narrow bus the high nibble goes first on lines 7:4
   task automatic xbyte(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
      logic [7:0] hi;
      if (nibble_mode)
      begin
         xfer(rs, rw, {d[7:4], ~d[3:0]}, hi);
         xfer(rs, rw, {d[3:0], ~d[7:4]}, q);
         q = {hi[7:4], q[7:4]};
      end
      else
         xfer(rs, rw, d, q);
   endtask

   // Operation, then busy polling and the half-period gap
   task automatic op(input logic rs, input logic rw, input logic [7:0] d,
                     input logic poll);
      logic [7:0] q;
      int         n;
      xbyte(rs, rw, d, q);
      if (rw)
      begin
         rd_data = q;
         rd_valid = 1'b1;
         @(posedge clk) #5 rd_valid = 1'b0;
      end
      n = 0;
      q = 8'hFF;
      while (poll && q[7] !== 1'b0 && n < 100)
      begin
         xbyte(1'b0, 1'b1, 8'h00, q);
         n++;
      end
      if (poll)
      begin
         repeat (19) @(posedge clk); // half of a 540 kHz period is 18.5 clocks
         #5;
      end
   endtask
endmodule

// ### verif/tb_char_lcd_instruction_unit.sv
// Self-checking bench for the instruction unit, driven through the host model.
// Assumes the core is reachable only at its ports; straps stay open (parallel) until the final serial-strap resets.
`timescale 1ns/1ns
module tb_char_lcd_instruction_unit;
   logic                  clk, rst_n, enable_strobe, register_select, read_write_select;
   logic                  db_oe_n, rd_valid, text_selected, display_visible, snap;
   logic [7:0]            db_in, db_out, scan_char, rd_data;
   logic [6:0]            scan_addr, e_ac;
   logic [5:0]            display_offset, e_off;
   logic                  e_txt, sel_hi, sel_lo, cursor_visible;
   logic [7:0]            tram [128];
   logic [7:0]            gram [64];
   cli_pkg::cli_cfg_type  cfg, e_cfg;
   cli_pkg::cli_duty_type duty;
   cli_pkg::cli_if_type   if_mode, e_if;
   logic [31:0]           exp_q [$];
   logic [31:0]           rnd = 32'hDE2F;
   int                    mismatches = 0;
   int                    samples_checked = 0;
   wire [30:0] state = {if_mode, cfg, duty, display_offset, text_selected, display_visible,
                        cursor_visible, scan_char};

   // 20 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   cli_core #(.BLINK_CYCLES(16)) cli_core_inst (.clk(clk), .rst_n(rst_n),
      .enable_strobe(enable_strobe), .register_select(register_select),
      .read_write_select(read_write_select), .db_in(db_in), .db_out(db_out),
      .db_oe_n(db_oe_n), .interface_sel_hi(sel_hi), .interface_sel_lo(sel_lo),
      .scan_addr(scan_addr), .scan_char(scan_char), .cfg(cfg), .duty(duty),
      .if_mode(if_mode), .address_counter(), .busy_indicator(),
      .text_selected(text_selected), .display_offset(display_offset),
      .display_visible(display_visible), .cursor_visible(cursor_visible), .cursor_solid());
   cli_host cli_host_inst (.clk(clk), .enable_strobe(enable_strobe),
      .register_select(register_select), .read_write_select(read_write_select),
      .db_in(db_in), .db_out(db_out), .db_oe_n(db_oe_n), .rd_valid(rd_valid),
      .rd_data(rd_data));

   // Oldest note against each read result or state snapshot
   always @(posedge clk)
      if (rd_valid || snap)
      begin
         samples_checked++;
         if (exp_q.size() == 0 || exp_q[0] !== (rd_valid ? {24'h0, rd_data} : {1'b1, state}))
         begin
            mismatches++;
            $display("[FAIL] %0t result differs from its note", $time);
         end
         if (exp_q.size() > 0)
            void'(exp_q.pop_front());
      end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Counter step; only the line-one end is modelled, tests avoid other wraps
   function automatic logic [6:0] nxt(input logic [6:0] a, input logic up);
      if (!up)
         return a - 7'h01;
      return (e_cfg.line_count && a == 7'h27) ? 7'h40 : a + 7'h01;
   endfunction
   function automatic logic [5:0] sh(input logic left);
      return 6'((int'(e_off) + (left ? 1 : 39)) % 40);
   endfunction

   // Note the expected state, then strobe a snapshot of the scanned cell
   task automatic snapshot(input logic [6:0] a);
      cli_pkg::cli_duty_type d;
      d = e_cfg.line_count  ? cli_pkg::DUTY_16 :
          e_cfg.font_height ? cli_pkg::DUTY_11 : cli_pkg::DUTY_8;
      scan_addr = a;
      repeat (2) @(posedge clk);
      exp_q.push_back({1'b1, e_if, e_cfg, d, e_off, e_txt, e_cfg.display_on,
                       e_cfg.display_on & e_cfg.cursor_on, tram[a]});
      #5 snap = 1'b1;
      @(posedge clk) #5 snap = 1'b0;
   endtask
   task automatic cmd(input logic [7:0] d);
      cli_host_inst.op(1'b0, 1'b0, d, 1'b1);
   endtask
   task automatic set_addr(input logic txt, input logic [6:0] a);
      cmd(txt ? {1'b1, a} : {2'h1, a[5:0]});
      e_ac = txt ? a : {1'b0, a[5:0]};
      e_txt = txt;
   endtask
   task automatic wr(input logic poll);
      rnd = lfsr(rnd);
      cli_host_inst.op(1'b1, 1'b0, rnd[7:0], poll);
      if (e_txt)
         tram[e_ac] = rnd[7:0];
      else
         gram[e_ac[5:0]] = rnd[7:0];
      if (e_txt && e_cfg.display_shift_enable)
         e_off = sh(e_cfg.address_direction);
      e_ac = nxt(e_ac, e_cfg.address_direction);
   endtask
   task automatic rd();
      exp_q.push_back({24'h0, e_txt ? tram[e_ac] : gram[e_ac[5:0]]});
      cli_host_inst.op(1'b1, 1'b1, 8'h00, 1'b1);
      e_ac = nxt(e_ac, e_cfg.address_direction);
   endtask
   task automatic stat(input logic busy);
      exp_q.push_back({24'h0, busy, e_ac});
      cli_host_inst.op(1'b0, 1'b1, 8'h00, 1'b1);
   endtask
   task automatic stop_test();
      if (exp_q.size() != 0)
         mismatches++;
      $display("Compared %0d results, %0d mismatches", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence: reset, formats, display controls, entry modes, shifts, narrow bus
   initial
   begin
      rst_n = 1'b0;
      scan_addr = 7'h00;
      snap = 1'b0;
      e_cfg = cli_pkg::CFG_RESET;
      e_ac = 7'h00;
      e_off = 6'h00;
      e_txt = 1'b1;
      e_if = cli_pkg::IF_PARALLEL;
      {sel_hi, sel_lo} = 2'h0;
      repeat (20) @(posedge clk);
      #5 rst_n = 1'b1;
      wr(1'b0);
      stat(1'b1);
      snapshot(7'h00);
      for (int i = 0; i < 4; i++)
      begin
         cmd(8'h30 | 8'(i << 2));
         {e_cfg.line_count, e_cfg.font_height} = 2'(i);
         snapshot(7'h00);
      end
      for (int i = 0; i < 8; i++)
      begin
         cmd(8'h08 | 8'(i));
         {e_cfg.display_on, e_cfg.cursor_on, e_cfg.blink_on} = 3'(i);
         snapshot(7'h00);
      end
      for (int i = 0; i < 4; i++)
      begin
         cmd(8'h04 | 8'(i));
         {e_cfg.address_direction, e_cfg.display_shift_enable} = 2'(i);
         set_addr(1'b1, 7'h10);
         wr(1'b1);
         stat(1'b0);
         set_addr(1'b1, 7'h10);
         rd();
         snapshot(7'h10);
      end
      set_addr(1'b0, 7'h05);
      wr(1'b1);
      set_addr(1'b0, 7'h05);
      rd();
      snapshot(7'h10);
      cmd(8'h06);
      e_cfg.display_shift_enable = 1'b0;
      set_addr(1'b1, 7'h26);
      wr(1'b1);
      wr(1'b1);
      stat(1'b0);
      wr(1'b1);
      for (int i = 0; i < 4; i++)
      begin
         cmd(8'h10 | 8'(i << 2));
         if (i[1])
            e_off = sh(!i[0]);
         else
            e_ac = nxt(e_ac, i[0]);
         stat(1'b0);
         snapshot(7'h40);
      end
      cmd(8'h10);
      e_ac = 7'h40;
      rd();
      set_addr(1'b1, 7'h27);
      cmd(8'h14);
      e_ac = 7'h40;
      rd();
      cli_host_inst.op(1'b0, 1'b0, 8'h28, 1'b0);
      cli_host_inst.nibble_mode = 1'b1;
      {e_cfg.bus_width_select, e_cfg.line_count, e_cfg.font_height} = 3'b010;
      stat(1'b1);
      set_addr(1'b1, 7'h05);
      wr(1'b0);
      stat(1'b1);
      set_addr(1'b1, 7'h05);
      rd();
      cli_host_inst.op(1'b0, 1'b0, 8'h38, 1'b0);
      cli_host_inst.nibble_mode = 1'b0;
      e_cfg.bus_width_select = 1'b1;
      stat(1'b1);
      snapshot(7'h05);
      // Mid-run resets with each serial strap; the parallel port must then be ignored
      for (int i = 1; i < 3; i++)
      begin
         rst_n = 1'b0;
         {sel_hi, sel_lo} = 2'(i);
         e_cfg = cli_pkg::CFG_RESET;
         {e_ac, e_off, e_txt} = {7'h00, 6'h00, 1'b1};
         e_if = i[0] ? cli_pkg::IF_TWO_WIRE : cli_pkg::IF_SERIAL4;
         repeat (4) @(posedge clk);
         #5 rst_n = 1'b1;
         cli_host_inst.op(1'b1, 1'b0, ~tram[0], 1'b0);
         snapshot(7'h00);
      end
      stop_test();
   end

   // Cuts a hang short; the sequence needs well under 2 ms
   initial
   begin
      #4000000;
      mismatches++;
      stop_test();
   end
endmodule
